// ===== pkg/twm_pkg.sv
// Shared constants and types for the 8-bit timer waveform generator.
package twm_pkg;

  localparam int unsigned TWM_WIDTH = 8;

  localparam logic [7:0] TWM_BOTTOM = 8'h00;
  localparam logic [7:0] TWM_MAX    = 8'hff;

  // Waveform mode select encodings.
  typedef enum logic [2:0] {
    TWM_MODE_NORMAL   = 3'b000,
    TWM_MODE_PC_MAX   = 3'b001,
    TWM_MODE_CLEAR    = 3'b010,
    TWM_MODE_FAST_MAX = 3'b011,
    TWM_MODE_RSVD_4   = 3'b100,
    TWM_MODE_PC_OCR   = 3'b101,
    TWM_MODE_RSVD_6   = 3'b110,
    TWM_MODE_FAST_OCR = 3'b111
  } twm_mode_t;

  // Output action encodings.
  localparam logic [1:0] TWM_ACT_OFF    = 2'h0;
  localparam logic [1:0] TWM_ACT_TOGGLE = 2'h1;
  localparam logic [1:0] TWM_ACT_CLEAR  = 2'h2;
  localparam logic [1:0] TWM_ACT_SET    = 2'h3;

  // Prescaler clock select encodings and divider masks.
  localparam logic [2:0] TWM_CS_STOP    = 3'h0;
  localparam logic [2:0] TWM_CS_DIV1    = 3'h1;
  localparam logic [2:0] TWM_CS_DIV8    = 3'h2;
  localparam logic [2:0] TWM_CS_DIV64   = 3'h3;
  localparam logic [2:0] TWM_CS_DIV256  = 3'h4;
  localparam logic [2:0] TWM_CS_DIV1024 = 3'h5;
  localparam int unsigned TWM_PRE_WIDTH = 10;
  localparam logic [9:0] TWM_MASK_DIV8    = 10'h007;
  localparam logic [9:0] TWM_MASK_DIV64   = 10'h03f;
  localparam logic [9:0] TWM_MASK_DIV256  = 10'h0ff;
  localparam logic [9:0] TWM_MASK_DIV1024 = 10'h3ff;
  localparam logic [9:0] TWM_PRE_RESET    = 10'h000;

  // State of the waveform generator core.
  typedef struct packed {
    logic [7:0] count;
    logic       count_down;
    logic [7:0] ocr_a;
    logic [7:0] ocr_b;
    logic       wave_a;
    logic       wave_b;
    logic       flag_a;
    logic       flag_b;
    logic       flag_ovf;
    logic       fix_a;
    logic       fix_b;
    logic       was_pc;
  } twm_state_t;

  localparam twm_state_t TWM_STATE_RESET = '0;

  typedef struct packed {
    logic [9:0] div;
  } twm_pre_state_t;

endpackage

// ===== verilog/twm_prescaler.sv
// Prescaler that turns the I/O clock into a timer clock enable.
module twm_prescaler (
  input  wire logic       sys_clk_i,      // I/O clock
  input  wire logic       resetn_i,       // Asynchronous reset, active low
  input  wire logic [2:0] clock_select_i, // Prescale factor select
  output logic            tick_o          // Timer clock enable
);
  import twm_pkg::*;

  twm_pre_state_t st_reg;
  twm_pre_state_t st_next;

  // The divider runs freely so a later select change lands on a shared phase.
  always_comb begin
    st_next     = st_reg;
    st_next.div = st_reg.div + 10'h001;
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_reg <= '{div: TWM_PRE_RESET};
    end else begin
      st_reg <= st_next;
    end
  end

  always_comb begin
    case (clock_select_i)
      TWM_CS_DIV1:    tick_o = 1'b1;
      TWM_CS_DIV8:    tick_o = (st_reg.div & TWM_MASK_DIV8) == TWM_MASK_DIV8;
      TWM_CS_DIV64:   tick_o = (st_reg.div & TWM_MASK_DIV64) == TWM_MASK_DIV64;
      TWM_CS_DIV256:  tick_o = (st_reg.div & TWM_MASK_DIV256) == TWM_MASK_DIV256;
      TWM_CS_DIV1024: tick_o = (st_reg.div & TWM_MASK_DIV1024) == TWM_MASK_DIV1024;
      default:        tick_o = 1'b0;
    endcase
  end

  div8_period_a : assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (clock_select_i == TWM_CS_DIV8) && tick_o ##1 (clock_select_i == TWM_CS_DIV8) [*8]
    |-> tick_o && !$past(tick_o, 1) && !$past(tick_o, 7))
    else $error("Divide-by-8 tick out of period.");

endmodule

// ===== verilog/twm_core.sv
// Waveform generator of an 8-bit timer: clear-on-match, fast PWM and phase-correct PWM.
// Summary of operation
// - Mode 2 counts up and clears to zero when count matches compare A.
// - In mode 2 compare A is live; a missed match wraps through 0xff.
// - In mode 2 compare A flag is set once per period at top.
// - In mode 2 action 1 toggles output A on every match.
// - In mode 2 overflow flag is set when count rolls from 0xff to zero.
// - Modes 3 and 7 count single slope; top is 0xff or compare A.
// - Fast PWM increments to top, then clears on the next timer tick.
// - Fast PWM action 2 clears on match, sets at bottom; action 3 inverts.
// - Fast PWM sets the overflow flag each time the count reaches top.
// - Fast PWM action 1 toggles output A only with mode bit 2; never B.
// - Fast PWM: compare zero gives one-tick spikes, compare max a steady level.
// - Fast PWM compare values are double buffered.
// - Modes 1 and 5 count dual slope; top is 0xff or compare A.
// - Phase-correct holds top for one timer tick, then counts down.
// - Phase-correct non-inverting clears on up match, sets on down match.
// - Phase-correct sets the overflow flag each time the count reaches bottom.
// - Phase-correct action 1 toggles output A only with mode bit 2.
// - Phase-correct compare zero gives steady low, max steady high, non-inverting.
// - Phase-correct forces the up-match level at bottom when a match was skipped.
// - A waveform reaches its pin only while the direction bit selects output.
// - Timer tick is the I/O clock divided by 1, 8, 64, 256 or 1024.
// - A compare match sets its flag at the following timer tick.
// - Flags clear on interrupt service or software write of one; set wins.
// - PWM modes load buffered compare values only at top.
// - Reset clears the waveform output state to zero.
module twm_core (
  input  wire logic       sys_clk_i,            // I/O clock
  input  wire logic       resetn_i,             // Asynchronous reset, active low
  input  wire logic [2:0] clock_select_i,       // Prescale select, 0 stops the timer
  input  wire logic [2:0] waveform_mode_select_i, // Waveform mode
  input  wire logic [1:0] output_a_action_i,    // Output A action
  input  wire logic [1:0] output_b_action_i,    // Output B action
  input  wire logic [7:0] compare_a_value_i,    // Compare A value written by software
  input  wire logic [7:0] compare_b_value_i,    // Compare B value written by software
  input  wire logic       compare_a_clr_i,      // Clear compare A flag
  input  wire logic       compare_b_clr_i,      // Clear compare B flag
  input  wire logic       overflow_clr_i,       // Clear overflow flag
  input  wire logic       dir_a_i,              // Pin A direction, 1 is output
  input  wire logic       dir_b_i,              // Pin B direction, 1 is output
  input  wire logic       port_a_data_i,        // Plain port data for pin A
  input  wire logic       port_b_data_i,        // Plain port data for pin B
  output logic [7:0]      timer_count_o,        // Counter value
  output logic            count_down_o,         // Counting direction, 1 is down
  output logic            compare_a_flag_o,     // Compare A flag
  output logic            compare_b_flag_o,     // Compare B flag
  output logic            overflow_flag_o,      // Overflow flag
  output logic            wave_out_a_o,         // Internal waveform A state
  output logic            wave_out_b_o,         // Internal waveform B state
  output logic            pin_a_o,              // Pin A output level
  output logic            pin_a_oe_o,           // Pin A output enable
  output logic            pin_b_o,              // Pin B output level
  output logic            pin_b_oe_o            // Pin B output enable
);
  import twm_pkg::*;

  twm_state_t st_reg;
  twm_state_t st_next;
  twm_mode_t  mode;
  logic       tick;
  logic       is_clear;
  logic       is_norm;
  logic       is_fast;
  logic       is_pc;
  logic       mode_bit2;
  logic [7:0] ocr_a_eff;
  logic [7:0] ocr_b_eff;
  logic [7:0] top;
  logic       at_top;
  logic       at_bot;
  logic       match_a;
  logic       match_b;
  logic       eff_up;
  logic       load_ocr;

  twm_prescaler u_prescaler (
    .sys_clk_i      (sys_clk_i),
    .resetn_i       (resetn_i),
    .clock_select_i (clock_select_i),
    .tick_o         (tick)
  );

  // Next level of one waveform output for one timer tick.
  function automatic logic twm_wave(input logic [1:0] act, input logic is_a,
                                    input logic bit2, input logic non_pwm,
                                    input logic fast, input logic pc,
                                    input logic match, input logic top_now,
                                    input logic bot_now, input logic up,
                                    input logic ocr_top, input logic fix,
                                    input logic wave);
    logic w;
    w = wave;
    if (non_pwm) begin
      if (match) begin
        case (act)
          TWM_ACT_TOGGLE: w = ~wave;
          TWM_ACT_CLEAR:  w = 1'b0;
          TWM_ACT_SET:    w = 1'b1;
          default:        w = wave;
        endcase
      end
    end else if (act == TWM_ACT_TOGGLE) begin
      if ((fast || pc) && is_a && bit2 && match) begin
        w = ~wave;
      end
    end else if (act[1] && fast) begin
      if (top_now) begin
        w = ~act[0];
      end else if (match && !ocr_top) begin
        w = act[0];
      end
    end else if (act[1] && pc) begin
      if (ocr_top) begin
        if (top_now) begin
          w = ~act[0];
        end
      end else if (match) begin
        w = up ? act[0] : ~act[0];
      end else if (bot_now && fix) begin
        w = act[0];
      end
    end
    return w;
  endfunction

  always_comb begin
    mode      = twm_mode_t'(waveform_mode_select_i);
    is_clear  = (mode == TWM_MODE_CLEAR);
    is_norm   = (mode == TWM_MODE_NORMAL);
    is_fast   = (mode == TWM_MODE_FAST_MAX) || (mode == TWM_MODE_FAST_OCR);
    is_pc     = (mode == TWM_MODE_PC_MAX) || (mode == TWM_MODE_PC_OCR);
    mode_bit2 = waveform_mode_select_i[2];
    // Without buffering the written value acts at once, which is why a late write can be missed.
    ocr_a_eff = (is_fast || is_pc) ? st_reg.ocr_a : compare_a_value_i;
    ocr_b_eff = (is_fast || is_pc) ? st_reg.ocr_b : compare_b_value_i;
    case (mode)
      TWM_MODE_CLEAR:    top = ocr_a_eff;
      TWM_MODE_PC_OCR:   top = ocr_a_eff;
      TWM_MODE_FAST_OCR: top = ocr_a_eff;
      default:           top = TWM_MAX;
    endcase
    at_top  = (st_reg.count == top);
    at_bot  = (st_reg.count == TWM_BOTTOM);
    match_a = (st_reg.count == ocr_a_eff);
    match_b = (st_reg.count == ocr_b_eff);
    // Bottom always counts as an up match and top, unless it is also bottom, as a down match.
    eff_up  = at_bot || (!st_reg.count_down && !at_top);
    load_ocr = (is_fast && at_top) || (is_pc && at_top && !st_reg.count_down);

    st_next = st_reg;
    st_next.was_pc = is_pc;
    if (!is_fast && !is_pc) begin
      st_next.ocr_a = compare_a_value_i;
      st_next.ocr_b = compare_b_value_i;
    end
    if (is_pc && !st_reg.was_pc) begin
      st_next.fix_a = st_reg.count > ocr_a_eff;
      st_next.fix_b = st_reg.count > ocr_b_eff;
    end

    // Flag clears act every cycle; a set in the same cycle wins.
    st_next.flag_a   = st_reg.flag_a & ~compare_a_clr_i;
    st_next.flag_b   = st_reg.flag_b & ~compare_b_clr_i;
    st_next.flag_ovf = st_reg.flag_ovf & ~overflow_clr_i;

    if (tick) begin
      if (match_a) begin
        st_next.flag_a = 1'b1;
      end
      if (match_b) begin
        st_next.flag_b = 1'b1;
      end
      case (mode)
        TWM_MODE_CLEAR: begin
          st_next.count = match_a ? TWM_BOTTOM : st_reg.count + 8'h01;
          if (st_reg.count == TWM_MAX) begin
            st_next.flag_ovf = 1'b1;
          end
        end
        TWM_MODE_FAST_MAX, TWM_MODE_FAST_OCR: begin
          st_next.count = at_top ? TWM_BOTTOM : st_reg.count + 8'h01;
          if (at_top) begin
            st_next.flag_ovf = 1'b1;
          end
        end
        TWM_MODE_PC_MAX, TWM_MODE_PC_OCR: begin
          if (at_top && at_bot) begin
            st_next.count_down = 1'b0;
          end else if (!st_reg.count_down) begin
            if (at_top) begin
              st_next.count_down = 1'b1;
              st_next.count      = st_reg.count - 8'h01;
            end else begin
              st_next.count = st_reg.count + 8'h01;
            end
          end else if (at_bot) begin
            st_next.count_down = 1'b0;
            st_next.count      = st_reg.count + 8'h01;
          end else begin
            st_next.count = st_reg.count - 8'h01;
          end
          if (at_bot && st_reg.count_down) begin
            st_next.flag_ovf = 1'b1;
          end
        end
        default: begin
          st_next.count = st_reg.count + 8'h01;
          if (st_reg.count == TWM_MAX) begin
            st_next.flag_ovf = 1'b1;
          end
        end
      endcase
      if (!is_pc) begin
        st_next.count_down = 1'b0;
      end

      st_next.wave_a = twm_wave(output_a_action_i, 1'b1, mode_bit2, is_clear || is_norm,
                                is_fast, is_pc, match_a, at_top, at_bot, eff_up,
                                ocr_a_eff == top, st_reg.fix_a, st_reg.wave_a);
      st_next.wave_b = twm_wave(output_b_action_i, 1'b0, mode_bit2, is_clear || is_norm,
                                is_fast, is_pc, match_b, at_top, at_bot, eff_up,
                                ocr_b_eff == top, st_reg.fix_b, st_reg.wave_b);

      if (load_ocr) begin
        st_next.ocr_a = compare_a_value_i;
        st_next.ocr_b = compare_b_value_i;
        if (is_pc) begin
          // Leaving max changes which level the down slope ends on.
          if (st_reg.ocr_a == TWM_MAX && compare_a_value_i != TWM_MAX) begin
            st_next.fix_a = 1'b1;
          end
          if (st_reg.ocr_b == TWM_MAX && compare_b_value_i != TWM_MAX) begin
            st_next.fix_b = 1'b1;
          end
        end
      end
      if (is_pc && at_bot) begin
        st_next.fix_a = 1'b0;
        st_next.fix_b = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_reg <= TWM_STATE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign timer_count_o    = st_reg.count;
  assign count_down_o     = st_reg.count_down;
  assign compare_a_flag_o = st_reg.flag_a;
  assign compare_b_flag_o = st_reg.flag_b;
  assign overflow_flag_o  = st_reg.flag_ovf;
  assign wave_out_a_o     = st_reg.wave_a;
  assign wave_out_b_o     = st_reg.wave_b;
  // The waveform overrides the port data whenever an action is selected.
  assign pin_a_o    = (output_a_action_i != TWM_ACT_OFF) ? st_reg.wave_a : port_a_data_i;
  assign pin_b_o    = (output_b_action_i != TWM_ACT_OFF) ? st_reg.wave_b : port_b_data_i;
  assign pin_a_oe_o = dir_a_i;
  assign pin_b_oe_o = dir_b_i;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);

  match_clear_a : assert property (tick && is_clear && match_a |=> timer_count_o == 8'h00)
    else $error("Clear-on-match count did not clear after match.");
  match_ovf_a : assert property (tick && is_clear && &timer_count_o |=> overflow_flag_o)
    else $error("Clear-on-match overflow flag missing after wrap.");
  cmp_flag_a : assert property (tick && match_a |=> compare_a_flag_o)
    else $error("Compare A flag not set after match.");
  flag_setwin_a : assert property (tick && match_b && compare_b_clr_i |=> compare_b_flag_o)
    else $error("Flag clear beat a simultaneous set.");
  fast_wrap_a : assert property (tick && is_fast && at_top ##0 $stable(waveform_mode_select_i)
    |=> timer_count_o == 8'h00 && overflow_flag_o)
    else $error("Fast PWM did not restart from bottom with overflow.");
  pc_turn_a : assert property (tick && is_pc && at_top && !at_bot && !count_down_o
    |=> count_down_o && timer_count_o == $past(timer_count_o) - 8'h01)
    else $error("Phase-correct did not turn at top.");
  pc_ovf_a : assert property (tick && is_pc && at_bot && count_down_o |=> overflow_flag_o)
    else $error("Phase-correct overflow flag missing at bottom.");
  tick_only_a : assert property (!tick |=> $stable(timer_count_o) && $stable(wave_out_a_o))
    else $error("Counter or output moved without a timer tick.");
  fast_buf_a : assert property (is_fast && !(tick && at_top) ##1 is_fast |-> $stable(st_reg.ocr_a))
    else $error("Fast PWM compare buffer changed mid-period.");
  fast_np_a : assert property (tick && is_fast && output_a_action_i == TWM_ACT_CLEAR && at_top
    && ocr_a_eff != top ##1 output_a_action_i == TWM_ACT_CLEAR |-> wave_out_a_o)
    else $error("Non-inverting fast PWM not set at bottom.");
  pin_dir_a : assert property (!dir_a_i |-> !pin_a_oe_o)
    else $error("Pin A driven while direction is input.");

  match_wrap_c : cover property (tick && is_clear && timer_count_o == 8'hff);
  fast_spike_c : cover property (tick && is_fast && match_a && ocr_a_eff == 8'h00);
  pc_fix_c     : cover property (tick && is_pc && at_bot && st_reg.fix_a);
  ovf_clr_c    : cover property (overflow_flag_o && overflow_clr_i);

endmodule

// ===== bench/twm_pin_load.sv
// Port pin with an external load, fed by the waveform pin driver.
module twm_pin_load (
  input  wire logic pin_i, // Level offered by the pin driver
  input  wire logic oe_i,  // Driver enable, 1 drives the pad
  output logic      pad_o  // Level seen on the pad
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last_reg;

  // A released pad floats, so show the inverse of the last driven level.
  always @(pin_i or oe_i) begin
    if (oe_i) begin
      last_reg = pin_i;
    end
  end
  assign pad_o = oe_i ? pin_i : ~last_reg;
endmodule

// ===== bench/tb.sv
// Self-checking bench for the timer waveform generator.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import twm_pkg::*;

  typedef struct {
    logic [2:0] m;
    logic [1:0] act;
    logic [7:0] cmp;
    int         n;
    logic [7:0] cnt;
    logic       w;
    logic       ovf;
  } twm_row_t;

  logic       clk = 0, rst_n = 0, clr_a = 0, clr_b = 0, clr_o = 0;
  logic       dir_a = 1, dir_b = 1, pd_a = 0, pd_b = 0;
  logic [2:0] cs = 3'h1, mode = 3'h2;
  logic [1:0] act_a = 2'h0, act_b = 2'h0;
  logic [7:0] cmp_a = 8'hff, cmp_b = 8'hff, cnt;
  logic       dn, fa, fb, fo, wa, wb, pa, pae, pb, pbe, pad_a, pad_b;
  int         fails = 0, compares = 0, cyc = 0;
  twm_row_t   rows[7];
  logic [7:0] pre_exp[4];

  twm_core twm_core_inst (
    .sys_clk_i(clk), .resetn_i(rst_n), .clock_select_i(cs),
    .waveform_mode_select_i(mode), .output_a_action_i(act_a),
    .output_b_action_i(act_b), .compare_a_value_i(cmp_a),
    .compare_b_value_i(cmp_b), .compare_a_clr_i(clr_a),
    .compare_b_clr_i(clr_b), .overflow_clr_i(clr_o), .dir_a_i(dir_a),
    .dir_b_i(dir_b), .port_a_data_i(pd_a), .port_b_data_i(pd_b),
    .timer_count_o(cnt), .count_down_o(dn), .compare_a_flag_o(fa),
    .compare_b_flag_o(fb), .overflow_flag_o(fo), .wave_out_a_o(wa),
    .wave_out_b_o(wb), .pin_a_o(pa), .pin_a_oe_o(pae), .pin_b_o(pb),
    .pin_b_oe_o(pbe)
  );
  twm_pin_load twm_pin_load_a_inst (.pin_i(pa), .oe_i(pae), .pad_o(pad_a));
  twm_pin_load twm_pin_load_b_inst (.pin_i(pb), .oe_i(pbe), .pad_o(pad_b));

  initial begin
    forever #25 clk = ~clk;
  end

  task automatic complete_run();
    $display("fails=%0d compares=%0d", fails, compares);
    if (fails == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // The ceiling leaves ample room over the roughly 2240 cycles of the tests.
  initial begin
    forever begin
      @(posedge clk);
      cyc++;
      if (cyc >= 6000) begin
        fails++;
        complete_run();
      end
    end
  end

  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: bit %b expected %b", $time, got, exp);
    end
  endtask

  task automatic run(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Inputs are set while reset is low, so the first edge after release counts.
  task automatic restart();
    rst_n = 0;
    run(6);
    chk_val(cnt, 8'h00);
    chk_bit(wa | wb, 1'b0);
    rst_n = 1;
  endtask

  initial begin
    rows[0] = '{3'h2, 2'h1, 8'h03, 6, 8'h02, 1'b1, 1'b0};
    rows[1] = '{3'h2, 2'h1, 8'h00, 5, 8'h00, 1'b1, 1'b0};
    rows[2] = '{3'h3, 2'h2, 8'h80, 260, 8'h04, 1'b1, 1'b1};
    rows[3] = '{3'h3, 2'h3, 8'h80, 260, 8'h04, 1'b0, 1'b1};
    rows[4] = '{3'h1, 2'h2, 8'h40, 450, 8'h3c, 1'b1, 1'b0};
    rows[5] = '{3'h3, 2'h1, 8'h10, 40, 8'h28, 1'b0, 1'b0};
    rows[6] = '{3'h5, 2'h2, 8'h40, 70, 8'h3b, 1'b1, 1'b0};
    pre_exp = '{8'h00, 8'h40, 8'h08, 8'h01};
    foreach (rows[i]) begin
      mode = rows[i].m;
      act_a = rows[i].act;
      act_b = rows[i].act;
      cmp_a = rows[i].cmp;
      cmp_b = rows[i].cmp;
      restart();
      run(rows[i].n);
      chk_val(cnt, rows[i].cnt);
      chk_bit(wa, rows[i].w);
      chk_bit(wb, rows[i].w);
      chk_bit(fo, rows[i].ovf);
    end
    // Prescale select 0 stops the timer; 1, 2 and 3 divide by 1, 8 and 64.
    mode = 3'h2;
    act_a = 2'h0;
    act_b = 2'h0;
    cmp_a = 8'hff;
    for (int i = 0; i < 4; i++) begin
      cs = 3'(i);
      restart();
      run(64);
      chk_val(cnt, pre_exp[i]);
    end
    // A compare value written below the count is missed until the wrap.
    cs = 3'h1;
    cmp_a = 8'h30;
    restart();
    run(32);
    cmp_a = 8'h05;
    run(223);
    chk_val(cnt, 8'hff);
    chk_bit(fo, 1'b0);
    run(1);
    chk_val(cnt, 8'h00);
    chk_bit(fo, 1'b1);
    chk_bit(fa, 1'b0);
    run(6);
    chk_val(cnt, 8'h00);
    run(1);
    chk_bit(fa, 1'b1);
    clr_a = 1;
    clr_o = 1;
    run(1);
    clr_a = 0;
    clr_o = 0;
    run(1);
    chk_bit(fa, 1'b0);
    chk_bit(fo, 1'b0);
    // Pin source and direction.
    cmp_a = 8'hff;
    pd_a = 1;
    pd_b = 1;
    restart();
    run(2);
    chk_bit(pad_a, 1'b1);
    chk_bit(pad_b, 1'b1);
    act_a = 2'h2;
    run(2);
    chk_bit(pad_a, 1'b0);
    dir_a = 0;
    run(1);
    chk_bit(pae, 1'b0);
    chk_bit(pbe, 1'b1);
    chk_bit(pad_a, 1'b1);
    // A clear that meets a compare match leaves the flag set.
    mode = 3'h2;
    cmp_a = 8'hff;
    cmp_b = 8'h03;
    restart();
    run(3);
    clr_b = 1;
    run(1);
    clr_b = 0;
    chk_bit(fb, 1'b1);
    run(1);
    clr_b = 1;
    run(1);
    clr_b = 0;
    chk_bit(fb, 1'b0);
    // Entering phase-correct above the compare value forces the up-match level at bottom.
    act_a = 2'h2;
    restart();
    run(128);
    cmp_a = 8'h40;
    run(1);
    mode = 3'h1;
    run(381);
    chk_val(cnt, 8'h00);
    chk_bit(dn, 1'b1);
    chk_bit(wa, 1'b1);
    chk_bit(fo, 1'b0);
    run(1);
    chk_bit(dn, 1'b0);
    chk_bit(fo, 1'b1);
    chk_bit(wa, 1'b0);
    // Top from compare A with toggle: A toggles on each match, B has no toggle.
    mode = 3'h7;
    act_a = 2'h1;
    act_b = 2'h1;
    cmp_a = 8'h02;
    cmp_b = 8'h01;
    restart();
    run(8);
    chk_val(cnt, 8'h01);
    chk_bit(wa, 1'b1);
    chk_bit(wb, 1'b0);
    chk_bit(fb, 1'b1);
    complete_run();
  end
endmodule
